/* tmce_pkg.sv */
// ============================================================
// shared constants for the transmit character encoder
// ============================================================
package tmce_pkg;

    // decoded state of a three-level select
    typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} tmce_lvl_type;

    // ============================================================
    // register map (byte addresses)
    // ============================================================
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;

    // control register fields
    localparam int CTRL_MODE_LO_POS = 0;
    localparam int CTRL_MODE_HI_POS = 2;
    localparam int CTRL_PAR_POS = 4;
    localparam int CTRL_CLK_POS = 6;
    localparam int CTRL_EN_POS = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // status register fields, one bit per channel each
    localparam int STAT_RD_POS = 0;
    localparam int STAT_WS_POS = 8;
    localparam int STAT_PERR_POS = 16;

    // ============================================================
    // character constants (code bit 0 = bit a, sent first)
    // ============================================================
    localparam logic [7:0] K285_BYTE = 8'hBC;
    localparam logic [9:0] C07_POS = 10'h079;
    localparam logic [9:0] K285_NEG = 10'h17C;
    localparam logic [9:0] K285_POS = 10'h283;
    localparam logic [3:0] WS_LAST = 4'hF;
    localparam logic [7:0] SPC_TBL1_SIZE = 8'h0C;

    // a floating (open) select reads as 2'b11 and counts as middle
    function automatic tmce_lvl_type tmce_lvl_dec(input logic [1:0] v);
        unique case (v)
            2'h0: return LVL_LOW;
            2'h2: return LVL_HIGH;
            default: return LVL_MID;
        endcase
    endfunction

endpackage

/* tmce_enc8b10b.sv */
`timescale 1ns/1ps
// ============================================================
// one 8b/10b code group with running disparity
// ============================================================
module tmce_enc8b10b (
    input wire logic [7:0] data_in,
    input wire logic k_in,
    input wire logic viol_in,
    input wire logic rd_in,
    output logic [9:0] code_out,
    output logic rd_out
);
    import tmce_pkg::*;

    // 5b/6b table, abcdei with a as msb, negative-disparity form
    function automatic logic [5:0] six_tab(input logic [4:0] x);
        logic [5:0] t [32];
        t = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
              6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
              6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
              6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
        return t[x];
    endfunction

    // 3b/4b table, fghj with f as msb, negative-disparity form
    function automatic logic [3:0] four_tab(input logic [2:0] y);
        logic [3:0] t [8];
        t = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
        return t[y];
    endfunction

    // ============================================================
    // encode
    // ============================================================
    always_comb
    begin
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] six;
        logic [3:0] four;
        logic rd_mid;
        logic alt7;
        logic [9:0] fwd;
        x = data_in[4:0];
        y = data_in[7:5];
        six = '0;
        four = '0;
        rd_mid = 1'b0;
        alt7 = 1'b0;
        fwd = '0;
        // k28 alone has its own 6b group; other specials reuse data groups
        six = (k_in && x == 5'h1C) ? 6'h0F : six_tab(x);
        if (rd_in && ($countones(six) != 3 || x == 5'h07))
            six = ~six;
        rd_mid = ($countones(six) != 3) ? ~rd_in : rd_in;
        // alternate x.7 avoids a run of five equal bits
        alt7 = (y == 3'h7) && (k_in || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
               || (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        four = alt7 ? 4'h7 : four_tab(y);
        if (rd_mid && ($countones(four) != 2 || y == 3'h3))
            four = ~four;
        else if (!rd_mid && k_in && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6))
            four = ~four;
        fwd = {six, four};
        for (int i = 0; i < 10; i++)
            code_out[i] = fwd[9-i];
        rd_out = ($countones(four) != 2) ? ~rd_mid : rd_mid;
        // violation group is neutral, so disparity is kept
        if (viol_in)
        begin
            code_out = rd_in ? ~C07_POS : C07_POS;
            rd_out = rd_in;
        end
    end

endmodule

/* tmce_tx_encoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - encoded modes turn characters into 8b/10b groups
// - data and special rules, correct running disparity
// - two disjoint special-code tables, many-to-one
// - ten-bit character to shifter, bit a first
// - two three-level selectors give nine modes
// - LL bypass; LM, LH reserved, no sync
// - select role: special, word sync, or none
// - bypass passes captured ten bits unchanged
// - bypass parity error sends fixed +C0.7 pattern
// - bypass bit order: data, control as h,j
// - bypass ignores select; channels stay independent
// - ML captures select with control bits
// - ML/HL control/select table, sync on 11
// - middle clock select: per-channel capture strobes
// - select sampled by channel A, shared same cycle
// - atomic sync under M, interruptible under H
// - sixteen K28.5, second and third reversed
// - encoded parity error outside atomic sync sends proper-disparity C0.7
module tmce_tx_encoder #(
    parameter int NCH = 4,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH*8-1:0] tx_char_data_bits,
    input wire logic [NCH*2-1:0] tx_char_ctrl_bits,
    input wire logic [NCH-1:0] tx_odd_parity_bits,
    input wire logic special_select_in,
    input wire logic [NCH-1:0] per_channel_tx_clock,
    output logic [NCH*10-1:0] tx_char_out,
    output logic [NCH-1:0] tx_char_valid,
    output logic [NCH-1:0] tx_parity_err
);
    import tmce_pkg::*;

    // ============================================================
    // declarations
    // ============================================================
    tmce_lvl_type mode_lo_ff, mode_hi_ff, par_sel_ff, clk_sel_ff; // frozen selects
    tmce_lvl_type nxt_mode_lo, nxt_mode_hi, nxt_par_sel, nxt_clk_sel;
    logic enable_ff, nxt_enable; // transmit path active
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [31:0] status_word; // live status view
    logic [NCH-1:0][7:0] cap_data_ff, nxt_cap_data; // input registers
    logic [NCH-1:0][1:0] cap_ctrl_ff, nxt_cap_ctrl;
    logic [NCH-1:0] cap_par_ff, nxt_cap_par, cap_valid_ff, nxt_cap_valid;
    logic ssel_ff, nxt_ssel; // select level as captured with channel A
    logic [NCH-1:0][9:0] out_ff, nxt_out; // characters to the shifter
    logic [NCH-1:0] valid_ff, nxt_valid, perr_ff, nxt_perr;
    logic [NCH-1:0] rd_ff, nxt_rd; // running disparity, 1 = positive
    logic [NCH-1:0] ws_act_ff, nxt_ws_act;
    logic [NCH-1:0][3:0] ws_cnt_ff, nxt_ws_cnt; // position in sync sequence
    logic [NCH-1:0][7:0] enc_byte;
    logic [NCH-1:0] enc_k, enc_viol, enc_inv, use_enc, enc_rd;
    logic [NCH-1:0][9:0] enc_code, byp_char;
    logic bypass; // encoder off

    assign bypass = (mode_hi_ff == LVL_LOW);
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign tx_char_out = out_ff;
    assign tx_char_valid = valid_ff;
    assign tx_parity_err = perr_ff;

    // special-code lookup: table one is a compact index, table two the raw k byte
    function automatic logic [8:0] spec_map(input logic [7:0] c);
        logic [7:0] k4 [4];
        k4 = '{8'hF7, 8'hFB, 8'hFD, 8'hFE};
        if (c < SPC_TBL1_SIZE)
            return {1'b1, (c[3] ? k4[c[1:0]] : {c[2:0], 5'h1C})};
        if (c[4:0] == 5'h1C || c == k4[0] || c == k4[1] || c == k4[2] || c == k4[3])
            return {1'b1, c};
        return 9'h000;
    endfunction

    // ============================================================
    // apb slave: one wait state, answer one cycle into the access phase
    // ============================================================
    always_comb
    begin
        status_word = '0;
        status_word[STAT_RD_POS +: NCH] = rd_ff;
        status_word[STAT_WS_POS +: NCH] = ws_act_ff;
        status_word[STAT_PERR_POS +: NCH] = perr_ff;
    end

    // next register and answer values
    always_comb
    begin
        nxt_pready = psel & penable & ~pready_ff;
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        nxt_enable = enable_ff;
        nxt_mode_lo = mode_lo_ff;
        nxt_mode_hi = mode_hi_ff;
        nxt_par_sel = par_sel_ff;
        nxt_clk_sel = clk_sel_ff;
        if (nxt_pready)
        begin
            // read data is staged one edge early, so it is stable with pready
            unique case (paddr)
                AW'(OFS_CTRL): nxt_prdata = {23'h0, enable_ff, 2'(clk_sel_ff), 2'(par_sel_ff),
                                             2'(mode_hi_ff), 2'(mode_lo_ff)};
                AW'(OFS_STATUS): nxt_prdata = status_word;
                default: nxt_prdata = 32'h0000_0000;
            endcase
            nxt_pslverr = (paddr != AW'(OFS_CTRL)) && (paddr != AW'(OFS_STATUS));
        end
        if (psel && penable && pready_ff && pwrite && paddr == AW'(OFS_CTRL))
        begin
            nxt_enable = pwdata[CTRL_EN_POS];
            // selects only move while the path is idle
            if (!enable_ff)
            begin
                nxt_mode_lo = tmce_lvl_dec(pwdata[CTRL_MODE_LO_POS +: 2]);
                nxt_mode_hi = tmce_lvl_dec(pwdata[CTRL_MODE_HI_POS +: 2]);
                nxt_par_sel = tmce_lvl_dec(pwdata[CTRL_PAR_POS +: 2]);
                nxt_clk_sel = tmce_lvl_dec(pwdata[CTRL_CLK_POS +: 2]);
            end
        end
    end

    // apb and control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            enable_ff <= CTRL_RST[CTRL_EN_POS];
            mode_lo_ff <= LVL_LOW;
            mode_hi_ff <= LVL_LOW;
            par_sel_ff <= LVL_LOW;
            clk_sel_ff <= LVL_LOW;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            enable_ff <= nxt_enable;
            mode_lo_ff <= nxt_mode_lo;
            mode_hi_ff <= nxt_mode_hi;
            par_sel_ff <= nxt_par_sel;
            clk_sel_ff <= nxt_clk_sel;
        end
    end

    // ============================================================
    // input registers
    // ============================================================
    always_comb
    begin
        nxt_cap_data = cap_data_ff;
        nxt_cap_ctrl = cap_ctrl_ff;
        nxt_cap_par = cap_par_ff;
        nxt_cap_valid = '0;
        nxt_ssel = ssel_ff;
        for (int ch = 0; ch < NCH; ch++)
        begin
            // low: every reference edge; middle: own strobe; high: channel A strobe
            if (enable_ff && (clk_sel_ff == LVL_LOW || (clk_sel_ff == LVL_MID ?
                per_channel_tx_clock[ch] : per_channel_tx_clock[0])))
            begin
                nxt_cap_valid[ch] = 1'b1;
                nxt_cap_data[ch] = tx_char_data_bits[ch*8 +: 8];
                nxt_cap_ctrl[ch] = tx_char_ctrl_bits[ch*2 +: 2];
                nxt_cap_par[ch] = tx_odd_parity_bits[ch];
            end
        end
        // select rides with channel A's capture and serves every channel
        if (enable_ff && (clk_sel_ff == LVL_LOW || per_channel_tx_clock[0]))
            nxt_ssel = special_select_in;
    end

    // input register flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_data_ff <= '0;
            cap_ctrl_ff <= '0;
            cap_par_ff <= '0;
            cap_valid_ff <= '0;
            ssel_ff <= 1'b0;
        end
        else
        begin
            cap_data_ff <= nxt_cap_data;
            cap_ctrl_ff <= nxt_cap_ctrl;
            cap_par_ff <= nxt_cap_par;
            cap_valid_ff <= nxt_cap_valid;
            ssel_ff <= nxt_ssel;
        end
    end

    // ============================================================
    // character selection: parity, mode tables, word sync
    // ============================================================
    always_comb
    begin
        logic perr;
        logic [1:0] c;
        logic cont;
        logic [8:0] sm; // special lookup: k flag and byte
        perr = 1'b0;
        sm = '0;
        c = 2'h0;
        cont = 1'b0;
        enc_byte = '0;
        enc_k = '0;
        enc_viol = '0;
        enc_inv = '0;
        use_enc = '0;
        nxt_valid = '0;
        nxt_perr = perr_ff;
        nxt_ws_act = ws_act_ff;
        nxt_ws_cnt = ws_cnt_ff;
        for (int ch = 0; ch < NCH; ch++)
        begin
            c = cap_ctrl_ff[ch];
            byp_char[ch] = {c, cap_data_ff[ch]};
            // odd parity; control bits join when high, or middle with bypass
            perr = (par_sel_ff != LVL_LOW) && !(^{cap_data_ff[ch], cap_par_ff[ch],
                   (par_sel_ff == LVL_HIGH || bypass) ? ^c : 1'b0});
            if (!enable_ff)
            begin
                nxt_ws_act[ch] = 1'b0;
                nxt_ws_cnt[ch] = 4'h0;
            end
            else if (cap_valid_ff[ch])
            begin
                nxt_valid[ch] = 1'b1;
                nxt_perr[ch] = perr;
                use_enc[ch] = !bypass;
                // atomic ignores input; interruptible needs 00 and good parity
                cont = ws_act_ff[ch] && (mode_hi_ff == LVL_MID || (c == 2'h0 && !perr));
                if (bypass)
                begin
                    nxt_ws_act[ch] = 1'b0;
                end
                else if (cont)
                begin
                    enc_byte[ch] = K285_BYTE;
                    enc_k[ch] = 1'b1;
                    enc_inv[ch] = (ws_cnt_ff[ch] == 4'h1) || (ws_cnt_ff[ch] == 4'h2);
                    nxt_perr[ch] = 1'b0;
                    nxt_ws_cnt[ch] = ws_cnt_ff[ch] + 4'h1;
                    nxt_ws_act[ch] = (ws_cnt_ff[ch] != WS_LAST);
                end
                else
                begin
                    nxt_ws_act[ch] = 1'b0;
                    nxt_ws_cnt[ch] = 4'h0;
                    enc_byte[ch] = cap_data_ff[ch];
                    if (perr)
                        enc_viol[ch] = 1'b1;
                    else if (mode_lo_ff == LVL_LOW ? (c == 2'h3) :
                             mode_lo_ff == LVL_MID ? (ssel_ff && c[0]) : (c == 2'h3))
                    begin
                        enc_byte[ch] = K285_BYTE;
                        enc_k[ch] = 1'b1;
                        nxt_ws_act[ch] = 1'b1;
                        nxt_ws_cnt[ch] = 4'h1;
                    end
                    else if (mode_lo_ff == LVL_HIGH ? (c == 2'h1) : (c[0] && (mode_lo_ff ==
                             LVL_LOW ? !ssel_ff : !c[1])))
                    begin
                        enc_byte[ch] = K285_BYTE;
                        enc_k[ch] = 1'b1;
                    end
                    else if (mode_lo_ff == LVL_HIGH ? (c == 2'h2) : c[0])
                    begin
                        sm = spec_map(cap_data_ff[ch]);
                        enc_k[ch] = sm[8];
                        enc_viol[ch] = !sm[8];
                        enc_byte[ch] = sm[7:0];
                    end
                end
            end
        end
    end

    // one encoder per channel
    for (genvar g = 0; g < NCH; g++)
    begin : g_enc
        tmce_enc8b10b u_enc (
            .data_in(enc_byte[g]),
            .k_in(enc_k[g]),
            .viol_in(enc_viol[g]),
            .rd_in(enc_inv[g] ? ~rd_ff[g] : rd_ff[g]),
            .code_out(enc_code[g]),
            .rd_out(enc_rd[g])
        );
    end

    // final character and disparity
    always_comb
    begin
        nxt_out = out_ff;
        nxt_rd = enable_ff ? rd_ff : '0;
        for (int ch = 0; ch < NCH; ch++)
        begin
            if (enable_ff && cap_valid_ff[ch])
            begin
                if (use_enc[ch])
                begin
                    nxt_out[ch] = enc_code[ch];
                    // reversed sync groups still step disparity as normal ones would
                    nxt_rd[ch] = enc_inv[ch] ? ~enc_rd[ch] : enc_rd[ch];
                end
                else
                    nxt_out[ch] = nxt_perr[ch] ? C07_POS : byp_char[ch];
            end
        end
    end

    // output and sequence flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_ff <= '0;
            valid_ff <= '0;
            perr_ff <= '0;
            rd_ff <= '0;
            ws_act_ff <= '0;
            ws_cnt_ff <= '0;
        end
        else
        begin
            out_ff <= nxt_out;
            valid_ff <= nxt_valid;
            perr_ff <= nxt_perr;
            rd_ff <= nxt_rd;
            ws_act_ff <= nxt_ws_act;
            ws_cnt_ff <= nxt_ws_cnt;
        end
    end

    // ============================================================
    // checks on channel 0, own-strobe capture check on the last channel
    // ============================================================
    sequence atomic_step;
        ws_act_ff[0] && cap_valid_ff[0] && enable_ff && mode_hi_ff == LVL_MID;
    endsequence

    sequence k285_out;
        out_ff[0] == K285_NEG || out_ff[0] == K285_POS;
    endsequence

    bypass_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && bypass && cap_valid_ff[0]
        |=> perr_ff[0] || out_ff[0] == {$past(cap_ctrl_ff[0]), $past(cap_data_ff[0])})
        else $error("bypass character altered");
    bypass_viol_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && bypass && cap_valid_ff[0] ##1 perr_ff[0] |-> out_ff[0] == C07_POS)
        else $error("bypass parity error not replaced");
    enc_viol_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && !bypass && cap_valid_ff[0] && !ws_act_ff[0] ##1 perr_ff[0]
        |-> out_ff[0] == (rd_ff[0] ? ~C07_POS : C07_POS))
        else $error("encoded parity error not a violation group");
    atomic_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        atomic_step |=> k285_out)
        else $error("atomic sync emitted non-k28.5");
    ws_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        ws_act_ff[0] |-> ws_cnt_ff[0] != 4'h0)
        else $error("sync position lost");
    code_bal_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && !bypass && cap_valid_ff[0]
        |=> $countones(out_ff[0]) >= 4 && $countones(out_ff[0]) <= 6)
        else $error("unbalanced code group");
    mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && $past(enable_ff) |-> $stable(mode_hi_ff) && $stable(mode_lo_ff))
        else $error("mode changed while active");
    chan_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && clk_sel_ff == LVL_MID && $past(enable_ff)
        |-> cap_valid_ff[NCH-1] == $past(per_channel_tx_clock[NCH-1]))
        else $error("capture not on own strobe");
    fill_char_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_ff && mode_hi_ff == LVL_MID && mode_lo_ff == LVL_LOW && cap_valid_ff[0]
        && !ws_act_ff[0] && cap_ctrl_ff[0] == 2'h1 && !ssel_ff && par_sel_ff == LVL_LOW
        |=> k285_out)
        else $error("fill character not k28.5");

endmodule

/* tmce_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// host logic: one strobe per character, all four channels
// ============================================================
module tmce_host_model (
    input wire logic pclk,
    output logic [31:0] tx_char_data_bits,
    output logic [7:0] tx_char_ctrl_bits,
    output logic [3:0] tx_odd_parity_bits,
    output logic special_select_in,
    output logic [3:0] per_channel_tx_clock
);
    // quiet at time zero
    initial
    begin
        tx_char_data_bits = '0;
        tx_char_ctrl_bits = '0;
        tx_odd_parity_bits = '0;
        special_select_in = 1'b0;
        per_channel_tx_clock = '0;
    end
    // channel n carries d+n; bad flips the odd parity bit
    task automatic send(input logic [7:0] d, input logic [1:0] c,
                        input logic s, input logic bad);
        logic [31:0] dv;
        logic [3:0] pv;
        for (int n = 0; n < 4; n++)
        begin
            dv[n*8+:8] = d + 8'(n);
            pv[n] = ~^{dv[n*8+:8], c} ^ bad;
        end
        @(posedge pclk);
        tx_char_data_bits <= dv;
        tx_char_ctrl_bits <= {4{c}};
        tx_odd_parity_bits <= pv;
        special_select_in <= s;
        per_channel_tx_clock <= 4'hF;
    endtask
    // released lines show the inverse so stale values never match
    task automatic idle();
        @(posedge pclk);
        per_channel_tx_clock <= 4'h0;
        tx_char_data_bits <= ~tx_char_data_bits;
        tx_char_ctrl_bits <= ~tx_char_ctrl_bits;
    endtask
endmodule

/* tmce_tx_encoder_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
// ============================================================
// bench: apb setup, bypass table, encoded fill and sync
// ============================================================
module tmce_tx_encoder_tb;
    import tmce_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [31:0] dat;
    logic [7:0] ctl;
    logic [3:0] opb, stb, vld, perr;
    logic sel;
    logic [39:0] cho;
    logic [39:0] q[$];
    logic [3:0] pq[$]; // parity flags beside each character
    int n_fail = 0, checks = 0, cyc = 0;
    // rows: data, control, expected channel-0 character
    localparam logic [19:0] ROWS [4] = '{{8'hA5, 2'h2, 10'h2A5},
        {8'h00, 2'h3, 10'h300}, {8'hFF, 2'h0, 10'h0FF}, {8'h21, 2'h1, 10'h121}};
    always #50 pclk = ~pclk;
    tmce_tx_encoder u_tmce_tx_encoder (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_char_data_bits(dat),
        .tx_char_ctrl_bits(ctl), .tx_odd_parity_bits(opb), .special_select_in(sel),
        .per_channel_tx_clock(stb), .tx_char_out(cho), .tx_char_valid(vld),
        .tx_parity_err(perr));
    tmce_host_model u_tmce_host_model (.pclk(pclk), .tx_char_data_bits(dat),
        .tx_char_ctrl_bits(ctl), .tx_odd_parity_bits(opb), .special_select_in(sel),
        .per_channel_tx_clock(stb));
    // collect every finished character
    always @(posedge pclk)
    begin
        cyc++;
        if (vld[0] === 1'b1)
        begin
            q.push_back(cho);
            pq.push_back(perr);
        end
        if (cyc == 3000)
        begin
            n_fail++; // hang cut short
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_q(input int n);
        while (q.size() < n)
            @(posedge pclk);
    endtask
    // k28.5 of a sync run that starts at negative disparity
    function automatic logic [9:0] kseq(input int i);
        if (i <= 2 || (i > 4 && i % 2 == 1))
            return K285_NEG;
        return K285_POS;
    endfunction
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge pclk);
        `CHK({vld, cho}, 44'h0)
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(r, CTRL_RST)
        apb(1'b0, 8'h08, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
        // bypass, parity high, own channel strobes
        apb(1'b1, OFS_CTRL, 32'h0000_0160);
        apb(1'b1, OFS_CTRL, 32'h0000_0184);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(r, 32'h0000_0160)
        foreach (ROWS[i])
            u_tmce_host_model.send(ROWS[i][19:12], ROWS[i][11:10], i[0], 1'b0);
        u_tmce_host_model.send(8'h3C, 2'h1, 1'b0, 1'b1);
        u_tmce_host_model.idle();
        wait_q(5);
        foreach (ROWS[i])
        begin
            `CHK(q[i][9:0], ROWS[i][9:0])
            `CHK(pq[i], 4'h0)
            `CHK(q[i][39:30], {ROWS[i][11:10], ROWS[i][19:12] + 8'h3})
        end
        `CHK(q[4], {4{C07_POS}})
        `CHK(pq[4], 4'hF)
        $display("test bypass done");
        // second reset mid-run clears outputs
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(cho, 40'h0)
        presetn <= 1'b1;
        q.delete();
        pq.delete();
        // upper middle, lower low, channel A strobe for all
        apb(1'b1, OFS_CTRL, 32'h0000_0184);
        u_tmce_host_model.send(8'h00, 2'h1, 1'b0, 1'b0);
        u_tmce_host_model.send(8'h00, 2'h1, 1'b0, 1'b0);
        u_tmce_host_model.send(8'h00, 2'h3, 1'b0, 1'b0);
        repeat (15)
            u_tmce_host_model.send(8'h55, 2'h0, 1'b0, 1'b0);
        u_tmce_host_model.send(8'h00, 2'h1, 1'b0, 1'b0);
        u_tmce_host_model.idle();
        wait_q(19);
        `CHK(q[0], {4{K285_NEG}})
        `CHK(q[1], {4{K285_POS}})
        for (int i = 1; i <= 16; i++)
            `CHK(q[i+1], {4{kseq(i)}})
        `CHK(q[18], {4{K285_NEG}})
        $display("test encoded done");
        // disable, then parity high: violation group, then both special tables
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0000_01A4);
        u_tmce_host_model.send(8'h00, 2'h0, 1'b0, 1'b1);
        u_tmce_host_model.send(8'h05, 2'h1, 1'b1, 1'b0);
        u_tmce_host_model.send(8'hBC, 2'h1, 1'b1, 1'b0);
        u_tmce_host_model.idle();
        wait_q(22);
        `CHK(q[19], {4{C07_POS}})
        `CHK(pq[19], 4'hF)
        `CHK(q[20][9:0], K285_NEG)
        `CHK(q[21][9:0], K285_POS)
        $display("test special done");
        complete_run();
    end
endmodule
